// [diff_source_model.sv]
`timescale 1ns/1ps
module diff_source_model #(
   parameter int GAP   = 8,
   parameter int MAG_W = 16
) (
   // clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // currents chosen by the bench
   input  wire logic [MAG_W-1:0] set0,
   input  wire logic [MAG_W-1:0] set1,
   input  wire logic [MAG_W-1:0] set2,
   // towards the detector
   output logic                  sample_strobe,
   output logic      [MAG_W-1:0] i0_mag,
   output logic      [MAG_W-1:0] i1_mag,
   output logic      [MAG_W-1:0] i2_mag,
   // from the detector
   input  wire logic             window_resize,
   output int                    resize_count
);
   int gap_cnt;

   // one source feeds the differential sums and the detector alike
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         gap_cnt <= 0;
         sample_strobe <= 1'b0;
         i0_mag <= '0;
         i1_mag <= '0;
         i2_mag <= '0;
      end
      else
      begin
         gap_cnt <= (gap_cnt == GAP - 1) ? 0 : gap_cnt + 1;
         sample_strobe <= (gap_cnt == GAP - 1);
         i0_mag <= set0;
         i1_mag <= set1;
         i2_mag <= set2;
      end
   end

   // each pulse would drop pre-fault samples from the window
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         resize_count <= 0;
      else if (window_resize)
         resize_count <= resize_count + 1;
   end
endmodule

// [disturbance_detector.sv]
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - Measure zero and negative sequence magnitudes and changes of all three sequences.
// - Currents arrive from the same source the line differential function uses.
// - Adaptive output rises when zero or negative sequence exceeds 0.12 pu.
// - While rising, threshold climbs 0.02 pu every 8 cycles, 0.12 to 0.24 pu.
// - Threshold saturates at 0.24 pu; outputs active while value exceeds threshold.
// - Falling, threshold steps down every 8 cycles; adaptive output stays inactive.
// - During descent supervision stays off while change remains below 0.04 pu.
// - Each delta detector picks up on a 0.04 pu sequence current change.
// - Change equals the absolute difference between present value and value from 4 cycles earlier.
// - Enable gates the whole detector; disabled gives no supervision output.
// - Selected non-current supervision input asserts output without current change.
// - Selected inhibit input blocks zero and negative sequence logic.
// - Selected hold input keeps output active until the input deasserts.
// - Output tells the differential function to resize its operating window.
// - Event logging of detector operations can be disabled separately.
module disturbance_detector #(
   parameter int MAG_W = 16
) (
   // clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // AHB-Lite slave
   input  wire logic             hsel,
   input  wire logic [7:0]       haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic      [31:0]      hrdata,
   output logic                  hreadyout,
   output logic                  hresp,
   // sequence magnitudes, one set per computation cycle
   input  wire logic             sample_strobe,
   input  wire logic [MAG_W-1:0] i0_mag,
   input  wire logic [MAG_W-1:0] i1_mag,
   input  wire logic [MAG_W-1:0] i2_mag,
   // supervision operands
   input  wire logic             noncurrent_supervision_input,
   input  wire logic             sequence_logic_inhibit,
   input  wire logic             output_hold_input,
   // results
   output logic                  disturbance_supervision_output,
   output logic                  adaptive_output,
   output logic                  window_resize,
   output logic                  detector_event,
   output logic                  irq
);

   localparam logic [MAG_W-1:0] THR_INIT = MAG_W'(disturbance_detector_pkg::THR_INITIAL);
   localparam logic [MAG_W-1:0] THR_MAX  = MAG_W'(disturbance_detector_pkg::THR_MAXIMUM);
   localparam logic [MAG_W-1:0] THR_STEP = MAG_W'(disturbance_detector_pkg::THR_STEP);
   localparam logic [MAG_W-1:0] DELTA_PU = MAG_W'(disturbance_detector_pkg::DELTA_PICKUP);
   localparam int HIST = disturbance_detector_pkg::HISTORY_CYCLES;
   localparam logic [2:0] STEP_LAST = 3'(disturbance_detector_pkg::STEP_CYCLES - 1);
   localparam logic [2:0] FILL_LAST = 3'(HIST);

   function automatic logic [MAG_W-1:0] abs_diff(input logic [MAG_W-1:0] a,
                                                 input logic [MAG_W-1:0] b);
      abs_diff = (a >= b) ? (a - b) : (b - a);
   endfunction

   // ---------------- register file ----------------
   logic [4:0]  ctrl;
   logic [1:0]  int_stat;
   logic [1:0]  int_mask;
   logic        dp_write;
   logic [7:0]  dp_addr;

   wire addr_ok   = hsel && hready && (htrans == disturbance_detector_pkg::HTRANS_NONSEQ);
   wire wr_ctrl   = dp_write && (dp_addr == disturbance_detector_pkg::CTRL_OFFSET);
   wire wr_istat  = dp_write && (dp_addr == disturbance_detector_pkg::INT_STAT_OFFSET);
   wire wr_imask  = dp_write && (dp_addr == disturbance_detector_pkg::INT_MASK_OFFSET);

   wire enable    = ctrl[disturbance_detector_pkg::CTRL_ENABLE_BIT];
   wire log_en    = ctrl[disturbance_detector_pkg::CTRL_LOG_BIT];
   wire nc_sel    = ctrl[disturbance_detector_pkg::CTRL_NC_SEL_BIT];
   wire inh_sel   = ctrl[disturbance_detector_pkg::CTRL_INH_SEL_BIT];
   wire hold_sel  = ctrl[disturbance_detector_pkg::CTRL_HOLD_SEL_BIT];

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_write <= 1'b0;
         dp_addr  <= 8'h00;
      end
      else
      begin
         dp_write <= addr_ok && hwrite && (hsize == disturbance_detector_pkg::HSIZE_WORD);
         dp_addr  <= haddr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl     <= disturbance_detector_pkg::CTRL_RESET;
         int_mask <= disturbance_detector_pkg::INT_RESET;
      end
      else
      begin
         if (wr_ctrl)
            ctrl <= hwdata[disturbance_detector_pkg::CTRL_WIDTH-1:0];
         if (wr_imask)
            int_mask <= hwdata[disturbance_detector_pkg::INT_WIDTH-1:0];
      end
   end

   // ---------------- measurement history ----------------
   logic [2:0]       fill;
   logic [MAG_W-1:0] present [3];
   logic [MAG_W-1:0] delta [3];

   assign present[0] = i0_mag;
   assign present[1] = i1_mag;
   assign present[2] = i2_mag;

   wire history_full = (fill == FILL_LAST);

   genvar q;
   generate
      for (q = 0; q < 3; q++)
      begin : g_seq
         // one history per sequence, so each array has a single driver
         logic [MAG_W-1:0] hist [HIST];

         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               for (int k = 0; k < HIST; k++)
                  hist[k] <= '0;
            end
            else if (sample_strobe)
            begin
               hist[0] <= present[q];
               for (int k = 1; k < HIST; k++)
                  hist[k] <= hist[k-1];
            end
         end
         assign delta[q] = abs_diff(present[q], hist[HIST-1]);
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         fill <= 3'h0;
      else if (sample_strobe && !history_full)
         fill <= fill + 3'h1;
   end

   // ---------------- adaptive level detector ----------------
   // open pole gives unbalanced load; block zero and negative sequence then
   wire seq_inhibit = inh_sel && sequence_logic_inhibit;
   wire [MAG_W-1:0] seq_level = seq_inhibit ? '0 :
                                (i0_mag > i2_mag) ? i0_mag : i2_mag;
   logic [MAG_W-1:0] thr;
   logic [2:0]       step_cnt;
   logic             climbing;

   wire above       = seq_level > thr;
   wire can_rise    = thr < THR_MAX;
   wire can_fall    = thr > THR_INIT;
   wire step_due    = (step_cnt == STEP_LAST);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         thr      <= THR_INIT;
         step_cnt <= 3'h0;
         climbing <= 1'b1;
      end
      else if (!enable)
      begin
         thr      <= THR_INIT;
         step_cnt <= 3'h0;
         climbing <= 1'b1;
      end
      else if (sample_strobe)
      begin
         climbing <= above;
         // the strobe that turns direction only restarts the count,
         // so a step needs eight further strobes that way
         if (above != climbing)
            step_cnt <= 3'h0;
         else if (above ? can_rise : can_fall)
         begin
            step_cnt <= step_due ? 3'h0 : step_cnt + 3'h1;
            if (step_due && above)
               thr <= thr + THR_STEP;
            else if (step_due)
               thr <= thr - THR_STEP;
         end
         else
            step_cnt <= 3'h0;
      end
   end

   // ---------------- delta detectors and output ----------------
   wire delta_i0  = !seq_inhibit && (delta[0] >= DELTA_PU);
   wire delta_i1  = delta[1] >= DELTA_PU;
   wire delta_i2  = !seq_inhibit && (delta[2] >= DELTA_PU);
   wire delta_any = history_full && (delta_i0 || delta_i1 || delta_i2);
   wire nc_active = nc_sel && noncurrent_supervision_input;
   wire hold_act  = hold_sel && output_hold_input;
   // descending threshold gives above=0, so only a delta or the selected non-current input can raise the output
   wire raw_sv    = above || delta_any || nc_active;
   wire next_sv   = !enable ? 1'b0 :
                    sample_strobe ? (raw_sv || (disturbance_supervision_output && hold_act)) :
                    disturbance_supervision_output;
   wire next_adapt = enable && (sample_strobe ? above : adaptive_output);
   logic sv_prev;
   logic adapt_prev;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         disturbance_supervision_output <= 1'b0;
         adaptive_output                <= 1'b0;
         sv_prev                        <= 1'b0;
         adapt_prev                     <= 1'b0;
      end
      else
      begin
         disturbance_supervision_output <= next_sv;
         adaptive_output                <= next_adapt;
         sv_prev                        <= disturbance_supervision_output;
         adapt_prev                     <= adaptive_output;
      end
   end

   wire sv_rise    = disturbance_supervision_output && !sv_prev;
   wire adapt_rise = adaptive_output && !adapt_prev;
   assign window_resize = sv_rise;
   // a busy system would flood the event store, so logging has its own switch
   assign detector_event = sv_rise && log_en;

   // ---------------- interrupt status ----------------
   wire [1:0] int_set = {adapt_rise, sv_rise} & {2{log_en}};
   wire [1:0] int_clr = wr_istat ? hwdata[disturbance_detector_pkg::INT_WIDTH-1:0] : 2'h0;
   // a new event wins over a clear written in the same cycle

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         int_stat <= disturbance_detector_pkg::INT_RESET;
      else
         int_stat <= (int_stat & ~int_clr) | int_set;
   end

   assign irq = |(int_stat & int_mask);

   // ---------------- read data ----------------
   wire [31:0] status_word = (32'(thr) << disturbance_detector_pkg::STATUS_THR_LSB)
                           | (32'(delta_any) << disturbance_detector_pkg::STATUS_DELTA_BIT)
                           | (32'(adaptive_output) << disturbance_detector_pkg::STATUS_ADAPT_BIT)
                           | (32'(disturbance_supervision_output)
                              << disturbance_detector_pkg::STATUS_SV_BIT);
   wire        rd_ctrl   = haddr == disturbance_detector_pkg::CTRL_OFFSET;
   wire        rd_status = haddr == disturbance_detector_pkg::STATUS_OFFSET;
   wire        rd_istat  = haddr == disturbance_detector_pkg::INT_STAT_OFFSET;
   wire        rd_imask  = haddr == disturbance_detector_pkg::INT_MASK_OFFSET;
   wire [31:0] rd_word   = rd_ctrl   ? 32'(ctrl) :
                           rd_status ? status_word :
                           rd_istat  ? 32'(int_stat) :
                           rd_imask  ? 32'(int_mask) : 32'h0000_0000;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (addr_ok && !hwrite)
         hrdata <= rd_word;
   end

   // ---------------- assertions ----------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_DISABLED_QUIET: assert property (!enable |=> !disturbance_supervision_output)
      else $error("supervision output active while detector disabled");

   AST_THR_RANGE: assert property (thr >= THR_INIT && thr <= THR_MAX)
      else $error("adaptive threshold left its range");

   AST_THR_STEP: assert property (enable && $changed(thr) |->
         $past(sample_strobe) && (thr == $past(thr) + THR_STEP || thr == $past(thr) - THR_STEP))
      else $error("threshold moved by a wrong amount or off strobe");

   AST_INITIAL_PICKUP: assert property (sample_strobe && enable && thr == THR_INIT &&
         seq_level > THR_INIT |=> adaptive_output && disturbance_supervision_output)
      else $error("adaptive detector missed initial pickup");

   AST_DESCENT_QUIET: assert property (sample_strobe && enable && !above |=>
         !adaptive_output)
      else $error("adaptive output active below threshold");

   AST_DELTA_PICKUP: assert property (sample_strobe && enable && history_full &&
         delta[1] >= DELTA_PU |=> disturbance_supervision_output)
      else $error("positive sequence change did not pick up");

   AST_DESCENT_NO_SV: assert property (sample_strobe && enable && !above && !delta_any &&
         !nc_active && !hold_act |=> !disturbance_supervision_output)
      else $error("supervision raised during quiet descent");

   AST_NONCURRENT: assert property (sample_strobe && enable && nc_active |=>
         disturbance_supervision_output)
      else $error("non-current input did not assert output");

   AST_INHIBIT: assert property (seq_inhibit |-> seq_level == '0 && !delta_i0 && !delta_i2)
      else $error("inhibit did not block sequence logic");

   AST_HOLD: assert property (disturbance_supervision_output && enable && hold_act
         ##1 enable |-> disturbance_supervision_output)
      else $error("held output dropped");

   AST_RESIZE: assert property ($rose(disturbance_supervision_output) |->
         window_resize ##1 !window_resize)
      else $error("window resize not a single pulse on output rise");

   AST_LOG_GATED: assert property (!log_en && !int_stat[0] |=> !int_stat[0])
      else $error("event recorded with logging disabled");

   AST_SV_ON_STROBE: assert property (enable && !sample_strobe |=>
         $stable(disturbance_supervision_output))
      else $error("supervision output changed between strobes");

   AST_ADAPT_IN_SV: assert property (adaptive_output |->
         disturbance_supervision_output)
      else $error("adaptive output active without supervision output");

   AST_THR_SATURATE: assert property (sample_strobe && enable && thr == THR_MAX &&
         above |=> thr == THR_MAX)
      else $error("threshold left its ceiling while level stayed high");

   AST_THR_FLOOR: assert property (sample_strobe && enable && thr == THR_INIT &&
         !above |=> thr == THR_INIT)
      else $error("threshold fell below its initial level");

   AST_HOLD_RELEASE: assert property (sample_strobe && enable && !raw_sv &&
         !hold_act |=> !disturbance_supervision_output)
      else $error("output stayed active after hold released");

   AST_EVENT_ON_RISE: assert property ($rose(disturbance_supervision_output) &&
         log_en |-> detector_event)
      else $error("logged output rise gave no event");

   AST_INT_SET_WINS: assert property (sv_rise && log_en |=>
         int_stat[disturbance_detector_pkg::INT_SV_RISE_BIT])
      else $error("supervision rise not recorded");

   AST_INT_CLEAR: assert property (wr_istat && !sv_rise &&
         hwdata[disturbance_detector_pkg::INT_SV_RISE_BIT] |=>
         !int_stat[disturbance_detector_pkg::INT_SV_RISE_BIT])
      else $error("write of one did not clear supervision status");

   COV_ADAPT_SATURATE: cover property (thr == THR_MAX && adaptive_output);
   COV_DESCENT: cover property (thr == THR_MAX ##[1:1000] thr == THR_INIT);
   COV_DELTA_ONLY: cover property (sample_strobe && enable && delta_any && !above);
   COV_NONCURRENT_ONLY: cover property (sample_strobe && enable && nc_active && !above &&
         !delta_any);
   COV_HOLD_EXTEND: cover property (disturbance_supervision_output && hold_act && !raw_sv &&
         sample_strobe);

endmodule

// [disturbance_detector_pkg.sv]
package disturbance_detector_pkg;

   // register byte offsets
   localparam logic [7:0] CTRL_OFFSET     = 8'h00;
   localparam logic [7:0] STATUS_OFFSET   = 8'h04;
   localparam logic [7:0] INT_STAT_OFFSET = 8'h08;
   localparam logic [7:0] INT_MASK_OFFSET = 8'h0C;

   // control field positions
   localparam int CTRL_ENABLE_BIT  = 0;
   localparam int CTRL_LOG_BIT     = 1;
   localparam int CTRL_NC_SEL_BIT  = 2;
   localparam int CTRL_INH_SEL_BIT = 3;
   localparam int CTRL_HOLD_SEL_BIT = 4;
   localparam int CTRL_WIDTH       = 5;
   localparam logic [4:0] CTRL_RESET = 5'h00;

   // status field positions
   localparam int STATUS_SV_BIT    = 0;
   localparam int STATUS_ADAPT_BIT = 1;
   localparam int STATUS_DELTA_BIT = 2;
   localparam int STATUS_THR_LSB   = 8;

   // interrupt event positions
   localparam int INT_SV_RISE_BIT    = 0;
   localparam int INT_ADAPT_RISE_BIT = 1;
   localparam int INT_WIDTH          = 2;
   localparam logic [1:0] INT_RESET  = 2'h0;

   // magnitudes in units of 0.01 pu
   localparam int THR_INITIAL  = 12;
   localparam int THR_MAXIMUM  = 24;
   localparam int THR_STEP     = 2;
   localparam int DELTA_PICKUP = 4;

   // counts in power-system computation cycles
   localparam int STEP_CYCLES    = 8;
   localparam int HISTORY_CYCLES = 4;

   // AHB-Lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        strobe;
   logic [15:0] mag_set [3];
   logic [15:0] i0;
   logic [15:0] i1;
   logic [15:0] i2;
   logic        nc_in;
   logic        inh_in;
   logic        hold_in;
   logic        sv;
   logic        adapt;
   logic        resize;
   logic        log_pulse;
   logic        irq;
   int          resize_count;
   int          bad_count;
   int          tests_run;
   int          cycles;
   int          c0;
   logic [31:0] rd;

   disturbance_detector DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_strobe(strobe),
      .i0_mag(i0), .i1_mag(i1), .i2_mag(i2), .noncurrent_supervision_input(nc_in),
      .sequence_logic_inhibit(inh_in), .output_hold_input(hold_in),
      .disturbance_supervision_output(sv), .adaptive_output(adapt),
      .window_resize(resize), .detector_event(log_pulse), .irq(irq));

   diff_source_model PARTNER (.hclk(hclk), .hresetn(hresetn), .set0(mag_set[0]),
      .set1(mag_set[1]), .set2(mag_set[2]), .sample_strobe(strobe), .i0_mag(i0),
      .i1_mag(i1), .i2_mag(i2), .window_resize(resize), .resize_count(resize_count));

   initial
   begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ceiling is about thirteen times the expected run
   always @(posedge hclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         bad_count = bad_count + 1;
         wrap_up();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         bad_count = bad_count + 1;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= disturbance_detector_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= disturbance_detector_pkg::HSIZE_WORD;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   // returns one cycle after the n-th strobe edge, outputs settled
   task automatic stb(input int n);
      repeat (n)
      begin
         @(posedge hclk);
         while (strobe !== 1'b1) @(posedge hclk);
      end
      @(posedge hclk);
   endtask

   initial
   begin
      {hsel, hwrite, nc_in, inh_in, hold_in} = 5'h00;
      haddr = 8'h00;
      htrans = 2'h0;
      hsize = 3'h0;
      hwdata = 32'h0;
      mag_set = '{16'h0, 16'h0, 16'h0};
      bad_count = 0;
      tests_run = 0;
      hresetn = 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(disturbance_detector_pkg::CTRL_OFFSET, 1'b0, 0);
      check("ctrl", rd, 32'h0);
      check("okay", hresp, 0);
      xfer(disturbance_detector_pkg::STATUS_OFFSET, 1'b0, 0);
      check("status", rd, 32'h00000C00);
      xfer(disturbance_detector_pkg::INT_MASK_OFFSET, 1'b0, 0);
      check("mask", rd, 32'h0);
      xfer(8'h10, 1'b0, 0);
      check("unmapped", rd, 32'h0);
      $display("test reset done");
      mag_set[2] <= 16'h001E;
      nc_in <= 1'b1;
      stb(6);
      check("sv off", sv, 0);
      check("adapt off", adapt, 0);
      mag_set[2] <= 16'h0000;
      nc_in <= 1'b0;
      stb(5);
      $display("test disabled done");
      xfer(disturbance_detector_pkg::INT_MASK_OFFSET, 1'b1, 32'h3);
      xfer(disturbance_detector_pkg::CTRL_OFFSET, 1'b1, 32'h3);
      c0 = resize_count;
      mag_set[2] <= 16'h001E;
      stb(1);
      check("sv rise", sv, 1);
      check("adapt rise", adapt, 1);
      check("event", log_pulse, 1);
      // counter and status register take the pulse one edge later
      repeat (2) @(posedge hclk);
      check("resize", resize_count, c0 + 1);
      check("irq", irq, 1);
      stb(7);
      // climb 12, 14 ... 24 then saturate
      for (int k = 14; k <= 26; k += 2)
      begin
         xfer(disturbance_detector_pkg::STATUS_OFFSET, 1'b0, 0);
         check("thr up", rd[23:8], (k > 24) ? 24 : k);
         check("sv hold", sv, 1);
         stb(8);
      end
      check("adapt sat", adapt, 1);
      xfer(disturbance_detector_pkg::INT_MASK_OFFSET, 1'b1, 32'h0);
      @(posedge hclk);
      check("irq masked", irq, 0);
      xfer(disturbance_detector_pkg::INT_STAT_OFFSET, 1'b1, 32'h3);
      xfer(disturbance_detector_pkg::INT_STAT_OFFSET, 1'b0, 0);
      check("stat clr", rd, 32'h0);
      $display("test climb done");
      mag_set[2] <= 16'h000C;
      // the turning strobe only restarts the count, so steps land on 9, 17 ... 49
      for (int k = 1; k <= 49; k++)
      begin
         stb(1);
         check("adapt down", adapt, 0);
         check("sv down", sv, k < 5);
         if (k % 8 == 1 && k > 1)
         begin
            xfer(disturbance_detector_pkg::STATUS_OFFSET, 1'b0, 0);
            check("thr down", rd[23:8], 24 - 2 * (k / 8));
         end
      end
      $display("test descent done");
      xfer(disturbance_detector_pkg::CTRL_OFFSET, 1'b1, 32'h1);
      mag_set[2] <= 16'h0000;
      stb(5);
      for (int ch = 0; ch < 3; ch++)
      begin
         mag_set[ch] <= 16'h0004;
         stb(1);
         check("quiet event", log_pulse, 0);
         stb(3);
         check("delta pick", sv, 1);
         stb(1);
         check("delta depth", sv, 0);
         mag_set[ch] <= 16'h0007;
         stb(1);
         check("delta small", sv, 0);
         mag_set[ch] <= 16'h0000;
         stb(5);
      end
      xfer(disturbance_detector_pkg::INT_STAT_OFFSET, 1'b0, 0);
      check("no log", rd, 32'h0);
      $display("test delta done");
      xfer(disturbance_detector_pkg::CTRL_OFFSET, 1'b1, 32'h9);
      inh_in <= 1'b1;
      mag_set[2] <= 16'h0014;
      stb(5);
      check("inhibit i2", sv, 0);
      mag_set[1] <= 16'h0004;
      stb(1);
      check("inhibit i1", sv, 1);
      mag_set[1] <= 16'h0000;
      mag_set[2] <= 16'h0000;
      stb(5);
      inh_in <= 1'b0;
      $display("test inhibit done");
      xfer(disturbance_detector_pkg::CTRL_OFFSET, 1'b1, 32'h5);
      nc_in <= 1'b1;
      stb(1);
      check("nc on", sv, 1);
      check("nc adapt", adapt, 0);
      nc_in <= 1'b0;
      stb(1);
      check("nc off", sv, 0);
      xfer(disturbance_detector_pkg::CTRL_OFFSET, 1'b1, 32'h1);
      nc_in <= 1'b1;
      stb(1);
      check("nc unsel", sv, 0);
      nc_in <= 1'b0;
      $display("test noncurrent done");
      xfer(disturbance_detector_pkg::CTRL_OFFSET, 1'b1, 32'h11);
      hold_in <= 1'b1;
      mag_set[1] <= 16'h0004;
      stb(6);
      check("held", sv, 1);
      hold_in <= 1'b0;
      stb(1);
      check("released", sv, 0);
      $display("test hold done");
      wrap_up();
   end
endmodule
